// file: logic/lic_regs_map.vh
// Register map and field layout of the line interface control bank.
// Assumes a byte-wide register space reached by word index on Avalon-MM.
`ifndef LIC_REGS_MAP_VH
`define LIC_REGS_MAP_VH

// ---------------------------------------------------------------------
// Register indices
// ---------------------------------------------------------------------
`define LIC_IDX_W 13
`define LIC_IDX_CTRL 13'h1000
`define LIC_IDX_SHAPE 13'h1001
`define LIC_IDX_MAINT 13'h1002
`define LIC_IDX_LIVE 13'h1003
`define LIC_IDX_MASK 13'h1004
`define LIC_IDX_LATCH 13'h1005
`define LIC_IDX_LEVEL 13'h1006
`define LIC_IDX_IMPMON 13'h1007
`define LIC_IDX_RSV_LO 13'h1008
`define LIC_IDX_RSV_HI 13'h101F

// ---------------------------------------------------------------------
// Reset values and write masks
// ---------------------------------------------------------------------
`define LIC_RST 8'h00
`define LIC_CTRL_WMASK 8'h1F
`define LIC_SHAPE_WMASK 8'h77

// ---------------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------------
`define LIC_CTRL_DEPTH 4
`define LIC_CTRL_POS_HI 3
`define LIC_CTRL_POS_LO 2
`define LIC_CTRL_STD 1
`define LIC_CTRL_LOSC 0
`define LIC_SHP_TOFF 6
`define LIC_SHP_IMP_HI 5
`define LIC_SHP_IMP_LO 4
`define LIC_SHP_LBO_HI 2
`define LIC_SHP_LBO_LO 0
`define LIC_MNT_FAIS 7
`define LIC_MNT_AAIS 6
`define LIC_MNT_NLOOP 5
`define LIC_MNT_ALOOP 4
`define LIC_MNT_FLOOP 3
`define LIC_MNT_TPD 2
`define LIC_MNT_RPD 1
`define LIC_MNT_TEN 0
`define LIC_LIV_LOS 0
`define LIC_LIV_OPEN 1
`define LIC_LIV_SHORT 2
`define LIC_LIV_UNDER 4
`define LIC_LIV_OVER 5

// ---------------------------------------------------------------------
// Codes
// ---------------------------------------------------------------------
`define LIC_DEPTH_DEEP 8'h80
`define LIC_DEPTH_SHALLOW 8'h20
`define LIC_POS_RX 2'h0
`define LIC_POS_TX 2'h1
`define LIC_LOS_G775 2'h0
`define LIC_LOS_ETS 2'h1
`define LIC_LOS_T1231 2'h2
`define LIC_IMP_75 2'h0
`define LIC_IMP_100 2'h1
`define LIC_IMP_110 2'h2
`define LIC_IMP_120 2'h3
`define LIC_LBO_E1_120 3'h1
`define LIC_LBO_CSU_FIRST 3'h5

`endif

// file: logic/lic_regs.v
// Line interface control and status register bank with Avalon-MM slave.
// Assumes live line conditions arrive synchronous to clk from the analog front end.
//
// Behaviour
// - Depth bit picks 128 or 32 bits.
// - Position field: receive, transmit, or bypass.
// - Standard bit: 0 E1, 1 T1/J1.
// - LOS criterion from standard and bit.
// - Termination off bit disables internal impedance.
// - Load impedance code 75/100/110/120 ohms.
// - Build-out code selects waveshape per standard.
// - Forced alarm sends all ones, ignores framer.
// - Auto alarm sends all ones on LOS.
// - Bit 5 enables local loopback.
// - Bit 4 enables analog loopback.
// - Remote loop retransmits receive, drops framer data.
// - Driver power-down tristates line outputs.
// - Receiver power-down bit powers receiver down.
// - Driver enable bit, overridden by pin.
// - Live LOS, open, short status bits.
// - Live over and under equalized bits.
// - Mask bits gate latched events onto interrupt.
// - Every latched bit latches, may interrupt.
//
// Our own choice: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`include "lic_regs_map.vh"

module lic_regs (
  // Clock, reset and clock enable
  input wire clk,
  input wire resetn,
  input wire clk_en,
  // Avalon-MM slave
  input wire [`LIC_IDX_W-1:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [7:0] avs_writedata,
  output reg [7:0] avs_readdata,
  output reg avs_waitrequest,
  // Live line conditions
  input wire los_live,
  input wire open_circuit_live,
  input wire short_circuit_live,
  input wire over_equalized_flag,
  input wire under_equalized_flag,
  input wire jitter_limit_live,
  input wire [3:0] rx_level_live,
  // Line data paths
  input wire driver_enable_pin,
  input wire framer_tx_bit,
  input wire line_rx_bit,
  // Line configuration outputs
  output reg [7:0] jitter_fifo_depth_sel,
  output reg [1:0] jitter_position_sel,
  output reg jitter_bypass,
  output reg line_standard_sel,
  output reg [1:0] los_criteria_sel,
  output reg tx_termination_off,
  output reg [1:0] tx_load_impedance_sel,
  output reg [2:0] tx_shape_sel,
  output reg tx_shape_csu,
  output reg near_end_loop,
  output reg internal_analog_loop,
  output reg far_end_loop,
  output reg receiver_power_down,
  output reg [3:0] rx_impedance_ctrl_unused,
  // Transmit line and interrupt outputs
  output reg line_out_bit,
  output reg alarm_ones_active,
  output reg line_out_oe_n,
  output reg line_irq
);

  // -------------------------------------------------------------------
  // Registers
  // -------------------------------------------------------------------
  reg [7:0] ctrl_q;
  reg [7:0] shape_q;
  reg [7:0] maint_q;
  reg [7:0] mask_q;
  reg [7:0] latch_q;
  reg [7:0] impmon_q;
  reg [7:0] live_q;
  reg jit_q;
  reg ack_q;
  reg [7:0] latch_d;
  reg [7:0] events;
  reg [7:0] rdata_d;
  wire [7:0] live_d;
  wire req;
  wire wr_hit;
  wire alarm_d;
  wire drive_d;

  function sel_hit;
    input [`LIC_IDX_W-1:0] a;
    input [`LIC_IDX_W-1:0] idx;
    begin
      sel_hit = (a == idx);
    end
  endfunction

  // -------------------------------------------------------------------
  // Live status
  // -------------------------------------------------------------------
  assign live_d = {2'h0, over_equalized_flag, under_equalized_flag, 1'b0,
                   short_circuit_live, open_circuit_live, los_live};

  // -------------------------------------------------------------------
  // Bus slave
  // -------------------------------------------------------------------
  assign req = (avs_read | avs_write) & ~ack_q;
  // A write lands only at the edge where the master sees waitrequest low.
  assign wr_hit = avs_write & ack_q;

  always @* begin
    case (avs_address)
      `LIC_IDX_CTRL: rdata_d = ctrl_q;
      `LIC_IDX_SHAPE: rdata_d = shape_q;
      `LIC_IDX_MAINT: rdata_d = maint_q;
      `LIC_IDX_LIVE: rdata_d = live_q;
      `LIC_IDX_MASK: rdata_d = mask_q;
      `LIC_IDX_LATCH: rdata_d = latch_q;
      `LIC_IDX_LEVEL: rdata_d = {rx_level_live, 4'h0};
      `LIC_IDX_IMPMON: rdata_d = impmon_q;
      default: rdata_d = 8'h00;
    endcase
  end

  // Rising edges set detect bits, falling edges set clear bits.
  always @* begin
    events = {jit_q & ~jitter_limit_live, live_q[1] & ~open_circuit_live,
              live_q[2] & ~short_circuit_live, live_q[0] & ~los_live,
              ~jit_q & jitter_limit_live, ~live_q[1] & open_circuit_live,
              ~live_q[2] & short_circuit_live, ~live_q[0] & los_live};
    latch_d = latch_q;
    if (wr_hit && sel_hit(avs_address, `LIC_IDX_LATCH)) begin
      latch_d = latch_q & ~avs_writedata;
    end
    latch_d = latch_d | events;
  end

  always @(posedge clk) begin
    if (!resetn) begin
      ctrl_q <= `LIC_RST;
      shape_q <= `LIC_RST;
      maint_q <= `LIC_RST;
      mask_q <= `LIC_RST;
      latch_q <= `LIC_RST;
      impmon_q <= `LIC_RST;
      live_q <= `LIC_RST;
      jit_q <= 1'b0;
      ack_q <= 1'b0;
      avs_readdata <= `LIC_RST;
      avs_waitrequest <= 1'b1;
      line_irq <= 1'b0;
    end else if (clk_en) begin
      live_q <= live_d;
      jit_q <= jitter_limit_live;
      latch_q <= latch_d;
      line_irq <= |(latch_d & mask_q);
      ack_q <= req;
      avs_waitrequest <= ~req;
      if (req) begin
        avs_readdata <= rdata_d;
      end
      // Reserved indices are expected to receive zeros only and are ignored.
      if (wr_hit) begin
        if (sel_hit(avs_address, `LIC_IDX_CTRL)) begin
          ctrl_q <= avs_writedata & `LIC_CTRL_WMASK;
        end
        if (sel_hit(avs_address, `LIC_IDX_SHAPE)) begin
          shape_q <= avs_writedata & `LIC_SHAPE_WMASK;
        end
        if (sel_hit(avs_address, `LIC_IDX_MAINT)) begin
          maint_q <= avs_writedata;
        end
        if (sel_hit(avs_address, `LIC_IDX_MASK)) begin
          mask_q <= avs_writedata;
        end
        if (sel_hit(avs_address, `LIC_IDX_IMPMON)) begin
          impmon_q <= avs_writedata;
        end
      end
    end
  end

  // -------------------------------------------------------------------
  // Configuration decode
  // -------------------------------------------------------------------
  assign alarm_d = maint_q[`LIC_MNT_FAIS] |
                   (maint_q[`LIC_MNT_AAIS] & live_q[`LIC_LIV_LOS]);
  assign drive_d = driver_enable_pin & maint_q[`LIC_MNT_TEN] &
                   ~maint_q[`LIC_MNT_TPD];

  // -------------------------------------------------------------------
  // Jitter attenuator settings
  // -------------------------------------------------------------------
  // Depth code of the attenuator FIFO.
  always @(posedge clk) begin
    if (!resetn) begin
      jitter_fifo_depth_sel <= `LIC_DEPTH_DEEP;
    end else if (clk_en) begin
      jitter_fifo_depth_sel <= ctrl_q[`LIC_CTRL_DEPTH] ? `LIC_DEPTH_SHALLOW :
                               `LIC_DEPTH_DEEP;
    end
  end

  // Position of the attenuator in the path.
  always @(posedge clk) begin
    if (!resetn) begin
      jitter_position_sel <= `LIC_POS_RX;
    end else if (clk_en) begin
      jitter_position_sel <= ctrl_q[`LIC_CTRL_POS_HI:`LIC_CTRL_POS_LO];
    end
  end

  // Upper position bit takes the attenuator out of the path.
  always @(posedge clk) begin
    if (!resetn) begin
      jitter_bypass <= 1'b0;
    end else if (clk_en) begin
      jitter_bypass <= ctrl_q[`LIC_CTRL_POS_HI];
    end
  end

  // -------------------------------------------------------------------
  // Line standard and loss criterion
  // -------------------------------------------------------------------
  // Line standard select.
  always @(posedge clk) begin
    if (!resetn) begin
      line_standard_sel <= 1'b0;
    end else if (clk_en) begin
      line_standard_sel <= ctrl_q[`LIC_CTRL_STD];
    end
  end

  // Loss criterion depends on both the standard and the criterion bit.
  always @(posedge clk) begin
    if (!resetn) begin
      los_criteria_sel <= `LIC_LOS_G775;
    end else if (clk_en) begin
      if (ctrl_q[`LIC_CTRL_STD]) begin
        los_criteria_sel <= `LIC_LOS_T1231;
      end else begin
        los_criteria_sel <= ctrl_q[`LIC_CTRL_LOSC] ? `LIC_LOS_ETS : `LIC_LOS_G775;
      end
    end
  end

  // -------------------------------------------------------------------
  // Transmit termination and waveshape
  // -------------------------------------------------------------------
  // Internal termination off.
  always @(posedge clk) begin
    if (!resetn) begin
      tx_termination_off <= 1'b0;
    end else if (clk_en) begin
      tx_termination_off <= shape_q[`LIC_SHP_TOFF];
    end
  end

  // Load impedance code.
  always @(posedge clk) begin
    if (!resetn) begin
      tx_load_impedance_sel <= `LIC_IMP_75;
    end else if (clk_en) begin
      tx_load_impedance_sel <= shape_q[`LIC_SHP_IMP_HI:`LIC_SHP_IMP_LO];
    end
  end

  // Build-out code.
  always @(posedge clk) begin
    if (!resetn) begin
      tx_shape_sel <= 3'h0;
    end else if (clk_en) begin
      tx_shape_sel <= shape_q[`LIC_SHP_LBO_HI:`LIC_SHP_LBO_LO];
    end
  end

  // Attenuation shapes exist only for the T1/J1 standard.
  always @(posedge clk) begin
    if (!resetn) begin
      tx_shape_csu <= 1'b0;
    end else if (clk_en) begin
      tx_shape_csu <= ctrl_q[`LIC_CTRL_STD] &
                      (shape_q[`LIC_SHP_LBO_HI:`LIC_SHP_LBO_LO] >= `LIC_LBO_CSU_FIRST);
    end
  end

  // -------------------------------------------------------------------
  // Loopbacks and power
  // -------------------------------------------------------------------
  // Local loopback.
  always @(posedge clk) begin
    if (!resetn) begin
      near_end_loop <= 1'b0;
    end else if (clk_en) begin
      near_end_loop <= maint_q[`LIC_MNT_NLOOP];
    end
  end

  // Analog loopback.
  always @(posedge clk) begin
    if (!resetn) begin
      internal_analog_loop <= 1'b0;
    end else if (clk_en) begin
      internal_analog_loop <= maint_q[`LIC_MNT_ALOOP];
    end
  end

  // Remote loopback.
  always @(posedge clk) begin
    if (!resetn) begin
      far_end_loop <= 1'b0;
    end else if (clk_en) begin
      far_end_loop <= maint_q[`LIC_MNT_FLOOP];
    end
  end

  // Receiver power-down.
  always @(posedge clk) begin
    if (!resetn) begin
      receiver_power_down <= 1'b0;
    end else if (clk_en) begin
      receiver_power_down <= maint_q[`LIC_MNT_RPD];
    end
  end

  // Upper half of the impedance monitor register.
  always @(posedge clk) begin
    if (!resetn) begin
      rx_impedance_ctrl_unused <= 4'h0;
    end else if (clk_en) begin
      rx_impedance_ctrl_unused <= impmon_q[7:4];
    end
  end

  // -------------------------------------------------------------------
  // Transmit line
  // -------------------------------------------------------------------
  // Alarm pattern in force.
  always @(posedge clk) begin
    if (!resetn) begin
      alarm_ones_active <= 1'b0;
    end else if (clk_en) begin
      alarm_ones_active <= alarm_d;
    end
  end

  // Alarm beats remote loopback, which beats framer data.
  always @(posedge clk) begin
    if (!resetn) begin
      line_out_bit <= 1'b0;
    end else if (clk_en) begin
      if (alarm_d) begin
        line_out_bit <= 1'b1;
      end else if (maint_q[`LIC_MNT_FLOOP]) begin
        line_out_bit <= line_rx_bit;
      end else begin
        line_out_bit <= framer_tx_bit;
      end
    end
  end

  // Driver output enable, low while driving.
  always @(posedge clk) begin
    if (!resetn) begin
      line_out_oe_n <= 1'b1;
    end else if (clk_en) begin
      line_out_oe_n <= ~drive_d;
    end
  end

endmodule // lic_regs

// file: dv/lic_line_model.sv
// Front end and framer model driving the live levels of the bank.
// Assumes the bench picks the levels; they change on the rising edge.
`timescale 1ns/100ps
module lic_line_model (
  // Bench control
  input wire clk,
  input wire [7:0] set,
  // Levels toward the bank
  output reg [7:0] live = 8'h00
);
  always @(posedge clk) live <= set;
endmodule // lic_line_model

// file: dv/lic_regs_chk.sv
// Port assertions for the line interface register bank.
// Assumes checks pause while clk_en is low.
`timescale 1ns/100ps
module lic_regs_chk (
  // Clock and reset
  input wire clk,
  input wire resetn,
  input wire clk_en,
  // Watched ports
  input wire [7:0] jitter_fifo_depth_sel,
  input wire [1:0] jitter_position_sel,
  input wire jitter_bypass,
  input wire line_standard_sel,
  input wire [1:0] los_criteria_sel,
  input wire [2:0] tx_shape_sel,
  input wire tx_shape_csu,
  input wire line_out_bit,
  input wire alarm_ones_active,
  input wire line_out_oe_n,
  input wire driver_enable_pin
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (!resetn || !clk_en);
  depth_code_a: assert property (jitter_fifo_depth_sel inside {8'h80, 8'h20})
    else $error("depth code illegal");
  bypass_pos_a: assert property (jitter_bypass == jitter_position_sel[1])
    else $error("bypass wrong");
  los_t1_a: assert property (line_standard_sel |-> los_criteria_sel == 2'h2)
    else $error("T1 loss criterion wrong");
  los_e1_a: assert property (!line_standard_sel |-> !los_criteria_sel[1])
    else $error("E1 loss criterion wrong");
  csu_shape_a: assert property (tx_shape_csu == (line_standard_sel && tx_shape_sel >= 3'h5))
    else $error("csu flag wrong");
  alarm_ones_a: assert property (alarm_ones_active && $past(alarm_ones_active) |-> line_out_bit)
    else $error("alarm not all ones");
  pin_off_a: assert property (!driver_enable_pin |=> line_out_oe_n)
    else $error("driver on with pin low");
  drive_cause_a: assert property (!line_out_oe_n |-> $past(driver_enable_pin))
    else $error("driver on without pin");
endmodule // lic_regs_chk

bind lic_regs lic_regs_chk i_lic_regs_chk (.clk(clk), .resetn(resetn), .clk_en(clk_en),
  .jitter_fifo_depth_sel(jitter_fifo_depth_sel), .jitter_position_sel(jitter_position_sel),
  .jitter_bypass(jitter_bypass), .line_standard_sel(line_standard_sel),
  .los_criteria_sel(los_criteria_sel), .tx_shape_sel(tx_shape_sel),
  .tx_shape_csu(tx_shape_csu), .line_out_bit(line_out_bit),
  .alarm_ones_active(alarm_ones_active), .line_out_oe_n(line_out_oe_n),
  .driver_enable_pin(driver_enable_pin));

// file: dv/lic_regs_tb.sv
// Self-checking bench for the line interface register bank.
// Assumes the map header and the line model are compiled alongside.
`timescale 1ns/100ps
`include "lic_regs_map.vh"
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin bad_count++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module lic_regs_tb;
  logic clk = 0, resetn = 0, rdq = 0, wrq = 0, pin = 1, ce = 1;
  logic [12:0] adr = 0;
  logic [7:0] wd = 0, rd, set = 0;
  wire [7:0] rdat, dep, lv;
  wire [1:0] pos, losc, imp;
  wire [2:0] shp;
  wire wait_q, byp, std, toff, csu, nl, al, fl, rpd, lob, alm, oe_n, irq;
  int bad_count = 0, comparisons = 0, cycles = 0;
  lic_line_model i_lic_line_model (.clk(clk), .set(set), .live(lv));
  lic_regs i_lic_regs (.clk(clk), .resetn(resetn), .clk_en(ce), .avs_address(adr),
    .avs_read(rdq), .avs_write(wrq), .avs_writedata(wd), .avs_readdata(rdat),
    .avs_waitrequest(wait_q), .los_live(lv[0]), .open_circuit_live(lv[1]),
    .short_circuit_live(lv[2]), .over_equalized_flag(lv[3]), .under_equalized_flag(lv[4]),
    .jitter_limit_live(lv[5]), .rx_level_live(4'h0), .driver_enable_pin(pin),
    .framer_tx_bit(lv[6]), .line_rx_bit(lv[7]), .jitter_fifo_depth_sel(dep),
    .jitter_position_sel(pos), .jitter_bypass(byp), .line_standard_sel(std),
    .los_criteria_sel(losc), .tx_termination_off(toff), .tx_load_impedance_sel(imp),
    .tx_shape_sel(shp), .tx_shape_csu(csu), .near_end_loop(nl), .internal_analog_loop(al),
    .far_end_loop(fl), .receiver_power_down(rpd), .rx_impedance_ctrl_unused(),
    .line_out_bit(lob), .alarm_ones_active(alm), .line_out_oe_n(oe_n), .line_irq(irq));
  initial forever #12.5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      bad_count++;
      give_verdict();
    end
  end
  task automatic acc(input logic w, input logic [12:0] a, input logic [7:0] d);
    @(posedge clk);
    adr <= a;
    wd <= d;
    wrq <= w;
    rdq <= !w;
    @(posedge clk);
    while (wait_q !== 1'b0) @(posedge clk);
    rd = rdat;
    wrq <= 0;
    rdq <= 0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic drive(input logic [7:0] s, input logic p);
    @(posedge clk);
    set <= s;
    pin <= p;
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic t_reset;
    for (int k = 0; k < 6; k++) begin
      acc(0, `LIC_IDX_CTRL + k, 8'h00);
      `CHK("reset value", 8'h00, rd)
    end
    `CHK("depth", 8'h80, dep)
    `CHK("driver off", 1'b1, oe_n)
  endtask
  task automatic t_ctrl;
    logic [2:0] i;
    for (int k = 0; k < 8; k++) begin
      i = k[2:0];
      acc(1, `LIC_IDX_CTRL, {3'h7, i[2], i[1:0], i[1], i[0]});
      `CHK("depth", i[2] ? 8'h20 : 8'h80, dep)
      `CHK("position", i[1:0], pos)
      `CHK("bypass", i[1], byp)
      `CHK("standard", i[1], std)
      `CHK("los criterion", i[1] ? 2'h2 : {1'b0, i[0]}, losc)
      acc(0, `LIC_IDX_CTRL, 8'h00);
      `CHK("ctrl readback", {3'h0, i[2], i[1:0], i[1], i[0]}, rd)
    end
  endtask
  task automatic t_shape;
    logic [2:0] i;
    acc(1, `LIC_IDX_CTRL, 8'h02);
    for (int k = 0; k < 8; k++) begin
      i = k[2:0];
      acc(1, `LIC_IDX_SHAPE, {1'b0, i[0], i[1:0], 1'b0, i});
      `CHK("termination", i[0], toff)
      `CHK("impedance", i[1:0], imp)
      `CHK("shape", i, shp)
      `CHK("csu", i >= 3'h5, csu)
    end
  endtask
  task automatic t_maint;
    drive(8'h80, 1);
    acc(1, `LIC_IDX_MAINT, 8'h39);
    `CHK("loops", 3'h7, {nl, al, fl})
    `CHK("far loop data", 1'b1, lob)
    `CHK("driver on", 1'b0, oe_n)
    acc(1, `LIC_IDX_MAINT, 8'h01);
    `CHK("framer data", 1'b0, lob)
    `CHK("loops off", 3'h0, {nl, al, fl})
    drive(8'h80, 0);
    `CHK("pin override", 1'b1, oe_n)
    drive(8'h00, 1);
    acc(1, `LIC_IDX_MAINT, 8'h07);
    `CHK("power down", 2'h3, {oe_n, rpd})
    acc(1, `LIC_IDX_MAINT, 8'h81);
    `CHK("forced alarm", 2'h3, {alm, lob})
    acc(1, `LIC_IDX_MAINT, 8'h41);
    drive(8'h01, 1);
    `CHK("auto alarm", 2'h3, {alm, lob})
    drive(8'h00, 1);
    `CHK("auto alarm gone", 1'b0, alm)
  endtask
  task automatic t_status;
    acc(1, `LIC_IDX_LATCH, 8'hFF);
    acc(1, `LIC_IDX_MASK, 8'h0F);
    drive(8'h3F, 1);
    acc(0, `LIC_IDX_LIVE, 8'h00);
    `CHK("live", 8'h37, rd)
    acc(0, `LIC_IDX_LATCH, 8'h00);
    `CHK("latched set", 9'h10F, {irq, rd})
    acc(1, `LIC_IDX_LATCH, 8'h0F);
    acc(0, `LIC_IDX_LATCH, 8'h00);
    `CHK("latched cleared", 9'h000, {irq, rd})
    drive(8'h00, 1);
    acc(0, `LIC_IDX_LATCH, 8'h00);
    `CHK("latched clear events", 9'h0F0, {irq, rd})
    acc(1, `LIC_IDX_MASK, 8'hF0);
    `CHK("irq unmasked", 1'b1, irq)
    acc(1, `LIC_IDX_LATCH, 8'hF0);
    `CHK("irq cleared", 1'b0, irq)
    acc(1, `LIC_IDX_LIVE, 8'hFF);
    acc(1, `LIC_IDX_RSV_LO, 8'h00);
    acc(0, `LIC_IDX_RSV_LO, 8'h00);
    `CHK("reserved", 8'h00, rd)
    acc(0, `LIC_IDX_LIVE, 8'h00);
    `CHK("live read only", 8'h00, rd)
  endtask
  task automatic t_freeze;
    acc(1, `LIC_IDX_MASK, 8'h01);
    @(posedge clk);
    ce <= 0;
    drive(8'h01, 1);
    `CHK("frozen irq", 1'b0, irq)
    @(posedge clk);
    ce <= 1;
    repeat (3) @(posedge clk);
    #1;
    `CHK("thawed irq", 1'b1, irq)
    acc(0, `LIC_IDX_LATCH, 8'h00);
    `CHK("thawed latch", 8'h01, rd)
  endtask
  task give_verdict;
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    resetn <= 1;
    t_reset();
    t_ctrl();
    t_shape();
    t_maint();
    t_status();
    t_freeze();
    give_verdict();
  end
endmodule // lic_regs_tb
